// >>> bmfe_encoder.sv
// Biphase-mark frame encoder: sync, 14-bit payload, parity, quiet gap
`timescale 1ns/1ns

// Functional notes
// RULE1 - Frame starts with sync bit setting unit period, then 14 payload bits, then parity.
// RULE2 - After parity, output stays quiet at idle level for eight unit periods.
// RULE3 - Whole frame is 24 unit periods; frames repeat back to back.
// RULE4 - A zero bit has no transition inside its period.
// RULE5 - A one bit has one mid-bit transition between 50 and 80 percent.
// RULE6 - Output toggles at the end of every transmitted bit.
// RULE7 - Upper twelve payload bits carry the current reading.
// RULE8 - Parity is one when the count of payload zeros is even.
// RULE9 - Sync bit leaves the idle level, so it is negative.
// RULE10 - New reading is latched only at frame start.
// RULE11 - With part-number output enabled, first two frames carry the part number.
// RULE12 - Receiver discards the first frame after power-up.
// RULE13 - Undervoltage blanks output and holds it high.
// RULE14 - Undervoltage blanking acts only when configuration is locked.
// RULE15 - Unit period is selectable: 40 us or 3.2 ms.
// RULE16 - One-bit mid transition sits nominally at 65 percent.
// RULE17 - Two low payload bits are zero.
// RULE18 - Bit timing counts clock cycles to a configured terminal count.
module bmfe_encoder #(
  parameter int FAST_CYC = bmfe_pkg::FAST_UNIT_CYC,
  parameter int SLOW_CYC = bmfe_pkg::SLOW_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration
  input wire logic slow_rate_i,
  input wire logic part_num_en_i,
  input wire logic [11:0] part_number_i,
  input wire logic cfg_locked_i,
  // Reading and supply monitor
  input wire logic [11:0] reading_i,
  input wire logic supply_low_threshold_i,
  // Open-drain output wire
  output logic line_o,
  output logic line_oe_o,
  // Status
  output logic frame_start_o,
  output logic [13:0] payload_field_o,
  output logic payload_parity_bit_o
);

  // ****************************************************************
  // Pin synchroniser and timing
  // ****************************************************************
  logic uv_meta_q;
  logic uv_sync_q;
  logic mid_w;
  logic end_w;

  // Supply monitor comes from analog, so two flops before use
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      uv_meta_q <= 1'b0;
      uv_sync_q <= 1'b0;
    end else begin
      uv_meta_q <= supply_low_threshold_i;
      uv_sync_q <= uv_meta_q;
    end
  end

  bmfe_unit_timer #(
    .FAST_CYC(FAST_CYC),
    .SLOW_CYC(SLOW_CYC)
  ) u_timer (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .slow_i(slow_rate_i),
    .mid_o(mid_w),
    .end_o(end_w)
  );

  // ****************************************************************
  // Frame sequencing
  // ****************************************************************
  logic [4:0] slot_q;
  logic [4:0] slot_d;
  logic [13:0] shift_q;
  logic [13:0] shift_d;
  logic parity_q;
  logic [1:0] part_cnt_q;
  logic [1:0] part_cnt_d;
  logic level_q;
  logic level_d;
  logic [13:0] payload_q;
  wire frame_end_w;
  wire in_bits_w;
  wire cur_bit_w;
  wire use_part_w;
  wire [13:0] next_payload_w;
  wire next_parity_w;
  wire blank_w;

  // Slot 0 sync, 1..14 payload, 15 parity, 16..23 gap
  assign frame_end_w = end_w && (slot_q == bmfe_pkg::SLOT_LAST); // see RULE3
  assign slot_d = frame_end_w ? bmfe_pkg::SLOT_RST : slot_q + 5'h01;
  assign in_bits_w = (slot_q <= bmfe_pkg::SLOT_PARITY); // see RULE1
  // Sync counts as a zero bit: no mid transition, its two edges bound the period
  assign cur_bit_w = (slot_q == bmfe_pkg::SLOT_RST) ? 1'b0
                   : (slot_q == bmfe_pkg::SLOT_PARITY) ? parity_q : shift_q[13];
  assign use_part_w = part_num_en_i && (part_cnt_q != 2'(bmfe_pkg::PART_REPEATS)); // see RULE11
  assign next_payload_w = {use_part_w ? part_number_i : reading_i, 2'h0}; // see RULE7 see RULE17
  // Parity set when zero count is even: xnor of all bits with an even width
  assign next_parity_w = ~(^next_payload_w); // see RULE8
  assign part_cnt_d = (frame_end_w && use_part_w) ? part_cnt_q + 2'h1 : part_cnt_q;
  assign shift_d = frame_end_w ? next_payload_w
                 : (end_w && slot_q != bmfe_pkg::SLOT_RST) ? {shift_q[12:0], 1'b0} : shift_q;

  // Line level: mid toggle for ones, end toggle for every bit, quiet in gap
  always_comb begin
    level_d = level_q; // Gap and zero bits hold their level, see RULE2
    if (in_bits_w && mid_w && cur_bit_w) begin
      level_d = ~level_q; // see RULE5 see RULE16
    end
    if (in_bits_w && end_w) begin
      level_d = ~level_q; // see RULE6 see RULE4
    end
    if (frame_end_w) begin
      level_d = ~bmfe_pkg::IDLE_LEVEL; // see RULE9
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      slot_q <= bmfe_pkg::SLOT_LAST;
      level_q <= bmfe_pkg::IDLE_LEVEL;
      shift_q <= bmfe_pkg::PAYLOAD_RST;
      parity_q <= 1'b0;
      payload_q <= bmfe_pkg::PAYLOAD_RST;
      part_cnt_q <= bmfe_pkg::PART_RST;
    end else begin
      if (end_w) begin
        slot_q <= slot_d;
      end
      level_q <= level_d;
      shift_q <= shift_d;
      part_cnt_q <= part_cnt_d;
      if (frame_end_w) begin
        parity_q <= next_parity_w; // see RULE10
        payload_q <= next_payload_w;
      end
    end
  end

  // ****************************************************************
  // Output stage
  // ****************************************************************
  // Blanking needs lock; unlocked parts stay programmable at low supply
  assign blank_w = uv_sync_q && cfg_locked_i; // see RULE14
  // Open drain: only a low level is driven, high comes from the pull-up
  logic line_oe_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_oe_q <= 1'b0;
    end else begin
      line_oe_q <= ~blank_w && ~level_d; // see RULE13
    end
  end
  assign line_o = 1'b0;
  assign line_oe_o = line_oe_q;
  assign frame_start_o = frame_end_w;
  assign payload_field_o = payload_q;
  assign payload_parity_bit_o = parity_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // The gap check looks one cycle ahead, so the toggle that ends parity is not caught
  a_gap_quiet: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE2
    (slot_q > bmfe_pkg::SLOT_PARITY) && !frame_end_w |=> $stable(level_q))
    else $error("Level changed during gap");
  a_sync_negative: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE9
    frame_end_w |=> (level_q == ~bmfe_pkg::IDLE_LEVEL) && (slot_q == 5'h00))
    else $error("Frame did not start with low sync");
  a_end_toggle: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE6
    end_w && in_bits_w |=> level_q != $past(level_q))
    else $error("No toggle at end of bit");
  a_zero_steady: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE4
    in_bits_w && !cur_bit_w && !end_w |=> level_q == $past(level_q))
    else $error("Zero bit changed level");
  a_one_mid: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE5
    in_bits_w && cur_bit_w && mid_w && !end_w |=> level_q != $past(level_q))
    else $error("One bit missed mid toggle");
  a_parity_even: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE8
    frame_end_w |=> parity_q == ~(^payload_q))
    else $error("Parity wrong");
  a_low_zero: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE17
    frame_end_w |=> payload_q[1:0] == 2'h0 && shift_q == payload_q)
    else $error("Low payload bits not zero");
  a_hold_value: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE10
    !frame_end_w |=> $stable(payload_q))
    else $error("Payload changed mid frame");
  a_uv_blank: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE13
    blank_w |=> !line_oe_o)
    else $error("Output driven while blanked");
  a_part_count: assert property (@(posedge clk_i) disable iff (srst_i) // see RULE11
    part_cnt_q <= 2'(bmfe_pkg::PART_REPEATS))
    else $error("Part number sent too often");

endmodule // bmfe_encoder

// >>> bmfe_encoder_tb.sv
// Self-checking testbench for the biphase-mark frame encoder
`timescale 1ns/1ns
module bmfe_encoder_tb;
  localparam int FU = 20;
  localparam int SU = 40;
  typedef struct packed {logic slow; logic [11:0] rd; logic par;} bmfe_row_type;
  bmfe_row_type rows [5] = '{'{1'b0, 12'h000, 1'b1}, '{1'b0, 12'hFFF, 1'b1},
    '{1'b0, 12'h001, 1'b0}, '{1'b1, 12'hABC, 1'b0}, '{1'b1, 12'hFFF, 1'b1}};
  logic clk_i = 1'b0, srst_i = 1'b1, slow_rate_i = 1'b0, part_num_en_i = 1'b1;
  logic cfg_locked_i = 1'b0, supply_low_threshold_i = 1'b0;
  logic [11:0] part_number_i = 12'hA5C, reading_i = 12'h123;
  logic line_o, line_oe_o, frame_start_o, payload_parity_bit_o, rx_par;
  logic [13:0] payload_field_o, rx_pay, prev;
  logic [7:0] rx_cnt;
  int rx_unit, rx_gap, checks = 0, miscompares = 0, n, u;
  // ****************************************************************
  // Clock, design, pulled-up wire and receiver
  // ****************************************************************
  initial forever #10 clk_i = ~clk_i;
  wire line_w = line_oe_o ? line_o : 1'b1; // Pull-up holds the idle level
  bmfe_encoder #(.FAST_CYC(FU), .SLOW_CYC(SU)) i_bmfe_encoder (.clk_i(clk_i),
    .srst_i(srst_i), .slow_rate_i(slow_rate_i), .part_num_en_i(part_num_en_i),
    .part_number_i(part_number_i), .cfg_locked_i(cfg_locked_i), .reading_i(reading_i),
    .supply_low_threshold_i(supply_low_threshold_i), .line_o(line_o),
    .line_oe_o(line_oe_o), .frame_start_o(frame_start_o),
    .payload_field_o(payload_field_o), .payload_parity_bit_o(payload_parity_bit_o));
  bmfe_rx_model i_bmfe_rx_model (.clk_i(clk_i), .wire_i(line_w), .rx_cnt_o(rx_cnt),
    .rx_pay_o(rx_pay), .rx_par_o(rx_par), .rx_unit_o(rx_unit), .rx_gap_o(rx_gap));
  // ****************************************************************
  // Compare, wait and verdict tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(string nm, logic [17:0] exp, logic [17:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Mid-run reset, then a bounded wait for the first sync of the new run
  task automatic restart();
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (3) @(negedge clk_i);
    cmp("rst", 18'h0, {3'h0, line_oe_o, payload_field_o});
    @(posedge clk_i);
    srst_i <= 1'b0;
    n = 0;
    while (frame_start_o !== 1'b1 && n < 3 * SU) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 3 * SU) begin
      miscompares++;
      print_verdict();
    end
    @(negedge clk_i);
  endtask
  // Bounded wait for k more decoded frames
  task automatic wait_rx(int k);
    logic [7:0] c0;
    for (int j = 0; j < k; j++) begin
      c0 = rx_cnt;
      n = 0;
      while (rx_cnt === c0) begin
        @(negedge clk_i);
        n++;
        if (n > 3000) begin
          miscompares++;
          print_verdict();
        end
      end
    end
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    wait_rx(1);
    cmp("part", {4'h0, 12'hA5C, 2'b00}, {4'h0, rx_pay});
    wait_rx(1);
    cmp("first", {4'h0, 12'h123, 2'b00}, {4'h0, rx_pay});
    prev = {12'h123, 2'b00};
    $display("power-up frames done");
    // Table rows: new reading and rate set in the gap
    foreach (rows[r]) begin
      u = rows[r].slow ? SU : FU;
      @(posedge clk_i);
      slow_rate_i <= rows[r].slow;
      reading_i <= rows[r].rd;
      @(negedge clk_i);
      cmp("hold", {4'h0, prev}, {4'h0, payload_field_o});
      wait_rx(2);
      prev = {rows[r].rd, 2'b00};
      cmp("pay", {4'h0, prev}, {4'h0, rx_pay});
      cmp("field", {4'h0, prev}, {4'h0, payload_field_o});
      cmp("par", {17'h0, rows[r].par}, {17'h0, rx_par});
      cmp("dpar", {17'h0, rows[r].par}, {17'h0, payload_parity_bit_o});
      cmp("unit", u[17:0], rx_unit[17:0]);
      cmp("gap", 18'(8 * u), rx_gap[17:0]);
      $display("row %0d done", r);
    end
    // Low supply while unlocked leaves frames running
    @(posedge clk_i);
    supply_low_threshold_i <= 1'b1;
    wait_rx(1);
    cmp("unlk", {4'h0, prev}, {4'h0, rx_pay});
    @(posedge clk_i);
    cfg_locked_i <= 1'b1;
    repeat (5) @(negedge clk_i);
    n = 0;
    repeat (24 * SU) begin
      @(negedge clk_i);
      n += int'(line_oe_o !== 1'b0);
    end
    cmp("blank", 18'h0, n[17:0]);
    $display("supply test done");
    // Reset in mid-run, then part number again; then a run without it
    @(posedge clk_i);
    supply_low_threshold_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    restart();
    cmp("rpart", {4'h0, 12'hA5C, 2'b00}, {4'h0, payload_field_o});
    cmp("sync", 18'h1, {17'h0, line_oe_o});
    @(posedge clk_i);
    part_num_en_i <= 1'b0;
    restart();
    cmp("nopart", {4'h0, 12'hFFF, 2'b00}, {4'h0, payload_field_o});
    cmp("nsync", 18'h1, {17'h0, line_oe_o});
    $display("reset test done");
    print_verdict();
  end
endmodule // bmfe_encoder_tb

// >>> bmfe_pkg.sv
// Package of constants for the biphase-mark frame encoder
package bmfe_pkg;

  // ****************************************************************
  // Frame layout
  // ****************************************************************
  localparam int PAYLOAD_BITS = 14;
  localparam int READING_BITS = 12;
  localparam int GAP_UNITS = 8;
  localparam int FRAME_UNITS = 24;
  localparam int PART_REPEATS = 2;
  localparam logic [4:0] SLOT_PARITY = 5'h0F;
  localparam logic [4:0] SLOT_LAST = 5'h17;

  // ****************************************************************
  // Timing at the 50 MHz clock
  // ****************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int FAST_UNIT_US = 40;
  localparam int SLOW_UNIT_US = 3200;
  localparam int FAST_UNIT_CYC = FAST_UNIT_US * (CLK_HZ / 1000000);
  localparam int SLOW_UNIT_CYC = SLOW_UNIT_US * (CLK_HZ / 1000000);
  localparam int MID_PERCENT = 65;
  localparam int CNT_W = 18;

  // ****************************************************************
  // Levels and reset values
  // ****************************************************************
  localparam logic IDLE_LEVEL = 1'b1;
  localparam logic [13:0] PAYLOAD_RST = 14'h0000;
  localparam logic [4:0] SLOT_RST = 5'h00;
  localparam logic [1:0] PART_RST = 2'h0;

endpackage

// >>> bmfe_rx_model.sv
// Receiver model that decodes the biphase-mark wire by edge timing
`timescale 1ns/1ns
module bmfe_rx_model (
  // Clock and wire
  input wire logic clk_i,
  input wire logic wire_i,
  // Decoded frame
  output logic [7:0] rx_cnt_o,
  output logic [13:0] rx_pay_o,
  output logic rx_par_o,
  output int rx_unit_o,
  output int rx_gap_o
);
  int n;
  int g;
  logic a;
  logic seen;
  logic [14:0] bits;
  // ****************************************************************
  // Decoder: sync length is the unit, each bit sampled early and late
  // ****************************************************************
  initial begin
    rx_cnt_o = 8'h00;
    seen = 1'b0;
    repeat (14) @(negedge clk_i);
    forever begin
      while (wire_i) @(negedge clk_i);
      n = 0;
      while (!wire_i) begin
        n++;
        @(negedge clk_i);
      end
      // Samples just before 50 and just after 80 percent: a mid edge outside
      // the legal window decodes wrongly and shows up as a bad payload
      for (int i = 0; i < 15; i++) begin
        repeat (n / 2 - 1) @(negedge clk_i);
        a = wire_i;
        repeat (n * 4 / 5 - n / 2 + 1) @(negedge clk_i);
        bits = {bits[13:0], a != wire_i};
        repeat (n - n * 4 / 5) @(negedge clk_i);
      end
      // First frame after power-up is thrown away
      if (seen) begin
        {rx_pay_o, rx_par_o} = bits;
        rx_unit_o = n;
        rx_cnt_o++;
      end
      seen = 1'b1;
      g = 0;
      while (wire_i && g < 2000) begin
        g++;
        @(negedge clk_i);
      end
      rx_gap_o = g;
    end
  end
endmodule // bmfe_rx_model

// >>> bmfe_unit_timer.sv
// Unit bit period timer producing mid-bit and end-of-bit strobes
`timescale 1ns/1ns
module bmfe_unit_timer #(
  parameter int FAST_CYC = bmfe_pkg::FAST_UNIT_CYC,
  parameter int SLOW_CYC = bmfe_pkg::SLOW_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Configuration
  input wire logic slow_i,
  // Strobes
  output logic mid_o,
  output logic end_o
);

  logic [bmfe_pkg::CNT_W-1:0] cnt_q;
  logic [bmfe_pkg::CNT_W-1:0] cnt_d;
  wire [bmfe_pkg::CNT_W-1:0] last_w;
  wire [bmfe_pkg::CNT_W-1:0] mid_w;

  // Terminal and mid counts from the configured unit period
  assign last_w = slow_i ? bmfe_pkg::CNT_W'(SLOW_CYC - 1)
                         : bmfe_pkg::CNT_W'(FAST_CYC - 1); // see RULE18 see RULE15
  assign mid_w = slow_i ? bmfe_pkg::CNT_W'(SLOW_CYC * bmfe_pkg::MID_PERCENT / 100)
                        : bmfe_pkg::CNT_W'(FAST_CYC * bmfe_pkg::MID_PERCENT / 100); // see RULE16
  assign end_o = (cnt_q >= last_w);
  assign mid_o = (cnt_q == mid_w);
  assign cnt_d = end_o ? '0 : cnt_q + bmfe_pkg::CNT_W'(1);

  // Free-running counter; a rate change takes effect at once
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // bmfe_unit_timer
